// *** logic/motor_holding_brake_control.sv ***
// Notes on behaviour
// - output high engages brake, low releases
// - supply 0 V engaged, 24 V released
// - brake engages as motor power drops
// - config 0..2: none, sequenced, always open
// - sequenced: open on switch-on rise, close at servo-off
// - opening delay 0..10000 ms before release
// - closing delay 0..10000 ms before engage
// - brake routable to either output, selections 1..14
// - closing starts after shorter of two watch times
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module motor_holding_brake_control import brake_pkg::*; #(
    parameter int MS_TICK_CYCLES = MS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic controlWordSwitchOnBit,
    input wire logic [NUM_SEL-1:0] doutFunc,
    output logic brakeHoldOutput,
    output logic brakeSupply24v,
    output logic motorPowerOn,
    output logic [NUM_DOUT-1:0] digitalOut
);
    localparam int MS_W = $clog2(MS_TICK_CYCLES + 1);
    localparam logic [MS_W-1:0] MS_RELOAD = MS_W'(MS_TICK_CYCLES - 1);

    logic [1:0] cfgSel_ff, nxt_cfgSel;
    logic [DLY_W-1:0] openDelay_ff, nxt_openDelay, closeDelay_ff, nxt_closeDelay;
    logic [DLY_W-1:0] zeroSpeed_ff, nxt_zeroSpeed, pulseInh_ff, nxt_pulseInh;
    logic [SEL_W-1:0] doutSel_ff [NUM_DOUT];
    logic [SEL_W-1:0] nxt_doutSel [NUM_DOUT];
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [31:0] wdat;
    logic wrEn;
    logic [DLY_W-1:0] wDly;
    logic [SEL_W-1:0] wSel;
    // declared here because the status read below reports the state
    brake_state_e state_ff, nxt_state;

    // apb slave: one wait state so every bus output is a flop
    always_comb begin
        nxt_cfgSel = cfgSel_ff;
        nxt_openDelay = openDelay_ff;
        nxt_closeDelay = closeDelay_ff;
        nxt_zeroSpeed = zeroSpeed_ff;
        nxt_pulseInh = pulseInh_ff;
        nxt_doutSel = doutSel_ff;
        wdat = pwdata;
        wDly = wdat[DLY_W-1:0];
        wSel = wdat[SEL_W-1:0];
        wrEn = psel && penable && pready_ff && pwrite;
        nxt_pready = psel && penable && !pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata = 32'h0000_0000;
        if (nxt_pready) begin
            unique case (paddr)
                OFS_CONFIG: nxt_prdata = {30'h0, cfgSel_ff};
                OFS_OPEN_DELAY: nxt_prdata = {18'h0, openDelay_ff};
                OFS_CLOSE_DELAY: nxt_prdata = {18'h0, closeDelay_ff};
                OFS_DOUT1_ASSIGN: nxt_prdata = {28'h0, doutSel_ff[0]};
                OFS_DOUT2_ASSIGN: nxt_prdata = {28'h0, doutSel_ff[1]};
                OFS_ZERO_SPEED: nxt_prdata = {18'h0, zeroSpeed_ff};
                OFS_PULSE_INHIBIT: nxt_prdata = {18'h0, pulseInh_ff};
                OFS_STATUS: nxt_prdata = {22'h0, motorPowerOn, brakeHoldOutput, 3'h0, state_ff};
                default: nxt_pslverr = 1'b1;
            endcase
        end
        // out-of-range values are dropped, the old setting stays
        if (wrEn && !pslverr_ff) begin
            unique case (paddr)
                OFS_CONFIG: if (wdat[31:2] == 30'h0 && wdat[1:0] <= CFG_OPEN) nxt_cfgSel = wdat[1:0];
                OFS_OPEN_DELAY: if (wdat <= 32'(DLY_MAX)) nxt_openDelay = wDly;
                OFS_CLOSE_DELAY: if (wdat <= 32'(DLY_MAX)) nxt_closeDelay = wDly;
                OFS_DOUT1_ASSIGN: if (wdat >= 32'(SEL_MIN) && wdat <= 32'(SEL_MAX)) nxt_doutSel[0] = wSel;
                OFS_DOUT2_ASSIGN: if (wdat >= 32'(SEL_MIN) && wdat <= 32'(SEL_MAX)) nxt_doutSel[1] = wSel;
                OFS_ZERO_SPEED: if (wdat <= 32'(DLY_MAX)) nxt_zeroSpeed = wDly;
                OFS_PULSE_INHIBIT: if (wdat <= 32'(DLY_MAX)) nxt_pulseInh = wDly;
                default: ;
            endcase
        end
    end

    // register file and bus answer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfgSel_ff <= CFG_RST;
            openDelay_ff <= OPEN_DLY_RST;
            closeDelay_ff <= CLOSE_DLY_RST;
            zeroSpeed_ff <= ZERO_SPEED_RST;
            pulseInh_ff <= PULSE_INH_RST;
            doutSel_ff[0] <= DOUT1_RST;
            doutSel_ff[1] <= DOUT2_RST;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            cfgSel_ff <= nxt_cfgSel;
            openDelay_ff <= nxt_openDelay;
            closeDelay_ff <= nxt_closeDelay;
            zeroSpeed_ff <= nxt_zeroSpeed;
            pulseInh_ff <= nxt_pulseInh;
            doutSel_ff <= nxt_doutSel;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    logic [DLY_W-1:0] delay_ff, nxt_delay, minWatch;
    logic [MS_W-1:0] msCnt_ff, nxt_msCnt;
    logic swPrev_ff, engaged_ff, nxt_engaged, power_ff, nxt_power;
    logic brakeOut_ff, nxt_brakeOut;
    logic [NUM_DOUT-1:0] dout_ff, nxt_dout;
    logic swRise, expired;

    // sequencer; delay of zero passes on the next edge
    always_comb begin
        nxt_state = state_ff;
        nxt_delay = delay_ff;
        nxt_msCnt = msCnt_ff;
        nxt_engaged = engaged_ff;
        nxt_power = power_ff;
        swRise = controlWordSwitchOnBit && !swPrev_ff;
        expired = (delay_ff == '0);
        minWatch = (zeroSpeed_ff < pulseInh_ff) ? zeroSpeed_ff : pulseInh_ff;
        // ms prescaler only advances while a delay is running
        if (!expired) begin
            if (msCnt_ff == '0) begin
                nxt_msCnt = MS_RELOAD;
                nxt_delay = delay_ff - 1'b1;
            end else begin
                nxt_msCnt = msCnt_ff - 1'b1;
            end
        end
        unique case (state_ff)
            ST_HELD: begin
                if (swRise) begin
                    nxt_state = ST_OPENING;
                    nxt_power = 1'b1;
                    nxt_delay = openDelay_ff;
                    nxt_msCnt = MS_RELOAD;
                end
            end
            ST_OPENING: begin
                if (!controlWordSwitchOnBit) begin
                    nxt_state = ST_STOPWAIT;
                    nxt_delay = minWatch;
                    nxt_msCnt = MS_RELOAD;
                end else if (expired) begin
                    nxt_state = ST_RUN;
                    nxt_engaged = 1'b0;
                end
            end
            ST_RUN: begin
                if (!controlWordSwitchOnBit) begin
                    nxt_state = ST_STOPWAIT;
                    nxt_delay = minWatch;
                    nxt_msCnt = MS_RELOAD;
                end
            end
            ST_STOPWAIT: begin
                if (expired) begin
                    nxt_state = ST_CLOSING;
                    nxt_delay = closeDelay_ff;
                    nxt_msCnt = MS_RELOAD;
                end
            end
            ST_CLOSING: begin
                // power drop and engage share one edge
                if (expired) begin
                    nxt_state = ST_HELD;
                    nxt_engaged = 1'b1;
                    nxt_power = 1'b0;
                end
            end
        endcase
        // only a sequenced brake ever gets engaged; else pin stays released
        nxt_brakeOut = (cfgSel_ff == CFG_SEQ) ? nxt_engaged : 1'b0;
    end

    // output routing: selection picks its function, brake code picks brake
    for (genvar d = 0; d < NUM_DOUT; d++) begin : g_dout
        assign nxt_dout[d] = (doutSel_ff[d] == SEL_BRAKE) ? nxt_brakeOut : doutFunc[doutSel_ff[d]];
    end

    // sequencer and pin registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff <= ST_HELD;
            delay_ff <= '0;
            msCnt_ff <= '0;
            swPrev_ff <= 1'b1;
            engaged_ff <= 1'b1;
            power_ff <= 1'b0;
            brakeOut_ff <= 1'b0;
            dout_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            delay_ff <= nxt_delay;
            msCnt_ff <= nxt_msCnt;
            swPrev_ff <= controlWordSwitchOnBit;
            engaged_ff <= nxt_engaged;
            power_ff <= nxt_power;
            brakeOut_ff <= nxt_brakeOut;
            dout_ff <= nxt_dout;
        end
    end

    logic supply_ff;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) supply_ff <= 1'b1;
        else supply_ff <= !nxt_brakeOut;
    end

    assign brakeHoldOutput = brakeOut_ff;
    assign brakeSupply24v = supply_ff;
    assign motorPowerOn = power_ff;
    assign digitalOut = dout_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_hold_level: assert property ((state_ff == ST_HELD && cfgSel_ff == CFG_SEQ && $stable(cfgSel_ff))
        |-> brakeHoldOutput && !(state_ff == ST_RUN)) else $error("brake not engaged while held");
    a_run_released: assert property (state_ff == ST_RUN |-> !brakeHoldOutput)
        else $error("brake engaged while running");
    a_supply_inverse: assert property (brakeSupply24v == !brakeHoldOutput)
        else $error("brake supply does not mirror hold level");
    a_power_engage: assert property ($fell(motorPowerOn) |-> state_ff == ST_HELD && engaged_ff
        && $past(state_ff) == ST_CLOSING) else $error("power dropped without engaging brake");
    a_cfg_range: assert property (cfgSel_ff <= CFG_OPEN)
        else $error("brake configuration out of range");
    a_open_rise: assert property ((state_ff == ST_HELD && controlWordSwitchOnBit && !swPrev_ff)
        |=> state_ff == ST_OPENING && motorPowerOn) else $error("switch-on rise not taken");
    a_open_load: assert property ($rose(state_ff == ST_OPENING) |-> delay_ff == $past(openDelay_ff)
        && delay_ff <= DLY_MAX) else $error("opening delay not loaded");
    a_close_load: assert property ($rose(state_ff == ST_CLOSING) |-> delay_ff == $past(closeDelay_ff))
        else $error("closing delay not loaded");
    a_route_brake: assert property ((doutSel_ff[0] == SEL_BRAKE && $stable(doutSel_ff[0]))
        |-> digitalOut[0] == brakeHoldOutput) else $error("output 1 does not carry brake");
    a_watch_min: assert property ($rose(state_ff == ST_STOPWAIT) |-> delay_ff == $past(minWatch)
        && delay_ff <= $past(zeroSpeed_ff) && delay_ff <= $past(pulseInh_ff))
        else $error("closing interval not after shorter watch time");
    a_tick_hold: assert property ((delay_ff != '0 && msCnt_ff != '0 && state_ff != ST_HELD
        && state_ff != ST_RUN && $stable(state_ff)) |=> delay_ff == $past(delay_ff) || state_ff != $past(state_ff))
        else $error("delay moved without a ms tick");

    c_open_done: cover property (state_ff == ST_OPENING ##1 state_ff == ST_RUN);
    c_close_done: cover property (state_ff == ST_CLOSING ##1 state_ff == ST_HELD && brakeHoldOutput);
    c_always_open: cover property (cfgSel_ff == CFG_OPEN && motorPowerOn);
    c_bus_error: cover property (pready && pslverr);
endmodule : motor_holding_brake_control

// *** pkg/brake_pkg.sv ***
package brake_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_OPEN_DELAY = 8'h04;
    localparam logic [7:0] OFS_CLOSE_DELAY = 8'h08;
    localparam logic [7:0] OFS_DOUT1_ASSIGN = 8'h0C;
    localparam logic [7:0] OFS_DOUT2_ASSIGN = 8'h10;
    localparam logic [7:0] OFS_ZERO_SPEED = 8'h14;
    localparam logic [7:0] OFS_PULSE_INHIBIT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // brake configuration codes
    localparam logic [1:0] CFG_NONE = 2'h0;
    localparam logic [1:0] CFG_SEQ = 2'h1;
    localparam logic [1:0] CFG_OPEN = 2'h2;
    localparam logic [1:0] CFG_RST = CFG_NONE;

    // delays in ms
    localparam int DLY_W = 14;
    localparam logic [DLY_W-1:0] DLY_MAX = 14'h2710;
    localparam logic [DLY_W-1:0] OPEN_DLY_RST = 14'h0064;
    localparam logic [DLY_W-1:0] CLOSE_DLY_RST = 14'h0064;
    localparam logic [DLY_W-1:0] ZERO_SPEED_RST = 14'h0FA0;
    localparam logic [DLY_W-1:0] PULSE_INH_RST = 14'h0064;

    // output routing selections
    localparam int SEL_W = 4;
    localparam int NUM_SEL = 15;
    localparam int NUM_DOUT = 2;
    localparam logic [SEL_W-1:0] SEL_MIN = 4'h1;
    localparam logic [SEL_W-1:0] SEL_MAX = 4'hE;
    localparam logic [SEL_W-1:0] SEL_BRAKE = 4'h8;
    localparam logic [SEL_W-1:0] DOUT1_RST = 4'h2;
    localparam logic [SEL_W-1:0] DOUT2_RST = 4'h9;

    // status register bit positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_BRAKE_BIT = 8;
    localparam int STAT_POWER_BIT = 9;

    // millisecond tick timing
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 25;
    localparam int MS_CYCLES = MS_NS / CLK_NS;

    typedef enum logic [4:0] {
        ST_HELD = 5'b00001,
        ST_OPENING = 5'b00010,
        ST_RUN = 5'b00100,
        ST_STOPWAIT = 5'b01000,
        ST_CLOSING = 5'b10000
    } brake_state_e;
endpackage : brake_pkg

// *** tb/brake_relay_model.sv ***
`timescale 1ns/1ps
// far side: relay stage whose coil current frees the motor shaft
module brake_relay_model (
    input wire logic ref_clk,
    input wire logic brakeHoldOutput,
    input wire logic brakeSupply24v,
    output logic shaftFree
);
    logic shaft_ff;
    logic nxt_shaft;
    // shaft turns only with hold low and 24 V present
    always_comb begin
        nxt_shaft = ~brakeHoldOutput & brakeSupply24v;
    end
    // relay reacts one clock late, like a real coil
    always_ff @(posedge ref_clk) begin
        shaft_ff <= nxt_shaft;
    end
    assign shaftFree = shaft_ff;
endmodule : brake_relay_model

// *** tb/motor_holding_brake_control_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin failCount++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module motor_holding_brake_control_tb import brake_pkg::*;;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic controlWordSwitchOnBit = 1'b0;
    logic [NUM_SEL-1:0] doutFunc = 15'h0000;
    logic brakeHoldOutput;
    logic brakeSupply24v;
    logic motorPowerOn;
    logic [NUM_DOUT-1:0] digitalOut;
    logic shaftFree;
    logic [31:0] rd;
    logic er;
    logic [SEL_W-1:0] s1;
    logic [SEL_W-1:0] s2;
    int failCount = 0;
    int numChecks = 0;
    logic [31:0] rstv [0:7] = '{32'(CFG_RST), 32'(OPEN_DLY_RST), 32'(CLOSE_DLY_RST), 32'(DOUT1_RST),
        32'(DOUT2_RST), 32'(ZERO_SPEED_RST), 32'(PULSE_INH_RST), 32'h0000_0001};
    logic [31:0] badv [0:4] = '{32'h3, 32'h2711, 32'h1_0000, 32'h0, 32'hF};

    motor_holding_brake_control #(.MS_TICK_CYCLES(4)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .controlWordSwitchOnBit(controlWordSwitchOnBit),
        .doutFunc(doutFunc), .brakeHoldOutput(brakeHoldOutput), .brakeSupply24v(brakeSupply24v),
        .motorPowerOn(motorPowerOn), .digitalOut(digitalOut));
    brake_relay_model i_relay (.ref_clk(ref_clk), .brakeHoldOutput(brakeHoldOutput),
        .brakeSupply24v(brakeSupply24v), .shaftFree(shaftFree));

    // 40 MHz clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // supply terminal must always mirror the hold output
    always @(negedge ref_clk) begin
        if (!sys_rst) `CHK(brakeSupply24v, ~brakeHoldOutput)
    end

    task stopTest;
        if (failCount == 0 && numChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stopTest

    // one apb transfer; waits for pready under a bound
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failCount++;
            stopTest();
        end
    endtask : apb

    // one switch-on / switch-off sequence with random delays
    task run(input logic [1:0] cfg);
        int n, m, z, p, t, k, relK, pwrK;
        n = $urandom_range(3);
        m = $urandom_range(3);
        z = $urandom_range(4, 1);
        p = $urandom_range(4, 1);
        t = 4 * ((z < p ? z : p) + m);
        apb(1'b1, OFS_CONFIG, 32'(cfg));
        apb(1'b1, OFS_OPEN_DELAY, 32'(n));
        apb(1'b1, OFS_CLOSE_DELAY, 32'(m));
        apb(1'b1, OFS_ZERO_SPEED, 32'(z));
        apb(1'b1, OFS_PULSE_INHIBIT, 32'(p));
        @(negedge ref_clk);
        `CHK(brakeHoldOutput, cfg == CFG_SEQ)
        @(posedge ref_clk);
        controlWordSwitchOnBit <= 1'b1;
        relK = 0;
        for (k = 1; k <= 4 * n + 3; k++) begin
            @(posedge ref_clk);
            @(negedge ref_clk);
            if (k == 1) `CHK(motorPowerOn, 1'b1)
            if (relK == 0 && brakeHoldOutput !== (cfg == CFG_SEQ)) relK = k;
        end
        `CHK(cfg == CFG_SEQ ? (relK >= 4 * n + 1 && relK <= 4 * n + 2) : relK == 0, 1'b1)
        `CHK(shaftFree, 1'b1)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK(rd, 32'h0000_0204)
        @(posedge ref_clk);
        controlWordSwitchOnBit <= 1'b0;
        pwrK = 0;
        // a fresh rise while stopping must not restart the drive
        for (k = 1; k <= t + 4 * n + 8; k++) begin
            @(posedge ref_clk);
            if (k == 2) controlWordSwitchOnBit <= 1'b1;
            @(negedge ref_clk);
            if (pwrK == 0 && motorPowerOn !== 1'b1) pwrK = k;
            `CHK(brakeHoldOutput, (cfg == CFG_SEQ) & ~motorPowerOn)
        end
        `CHK(pwrK >= t + 1 && pwrK <= t + 4, 1'b1)
        `CHK(motorPowerOn, 1'b0)
        `CHK(shaftFree, cfg != CFG_SEQ)
        @(posedge ref_clk);
        controlWordSwitchOnBit <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : run

    initial begin
        void'($urandom(32'hBF5F0F3F));
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // reset values, then out-of-range writes that must be ignored
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rd, rstv[i])
        end
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'(4 * i), badv[i]);
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rd, rstv[i])
        end
        apb(1'b1, OFS_CLOSE_DELAY, 32'h2710);
        apb(1'b0, OFS_CLOSE_DELAY, 32'h0);
        `CHK(rd, 32'(DLY_MAX))
        apb(1'b0, 8'h20, 32'h0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        // routing while held with sequenced brake engaged
        apb(1'b1, OFS_CONFIG, 32'(CFG_SEQ));
        for (int i = 0; i < 8; i++) begin
            s1 = i == 0 ? SEL_BRAKE : 4'($urandom_range(14, 1));
            s2 = i == 1 ? SEL_BRAKE : 4'($urandom_range(14, 1));
            apb(1'b1, OFS_DOUT1_ASSIGN, 32'(s1));
            apb(1'b1, OFS_DOUT2_ASSIGN, 32'(s2));
            doutFunc <= 15'($urandom);
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK(digitalOut[0], s1 == SEL_BRAKE ? 1'b1 : doutFunc[s1])
            `CHK(digitalOut[1], s2 == SEL_BRAKE ? 1'b1 : doutFunc[s2])
        end
        for (int r = 0; r < 6; r++) begin
            run(2'(r % 3));
        end
        stopTest();
    end
endmodule : motor_holding_brake_control_tb
